//--- design/rgbd_core.sv
/*
  control core of a three channel led driver: mode sequencing, latched flags,
  i2c target with auto increment, commands, and per channel fade ramps.
  assumes scl/sda come from an external controller on pins; scl is also sampled by the
  link-side sleep detection, which runs in a separate clock domain on link_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module rgbd_core
  import rgbd_pkg::*;
#(
  parameter longint SLEEP_CYC = SCL_LOW_SLEEP_CYC
) (
  // clocks and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        link_clk_i,
  // analog monitors
  input  wire logic        supply_low_lockout_i,
  input  wire logic        over_temp_i,
  // i2c pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // channel outputs
  output logic [7:0]       ch0_pwm_o,
  output logic [7:0]       ch1_pwm_o,
  output logic [7:0]       ch2_pwm_o,
  output logic [2:0]       ch_on_o,
  output logic [2:0]       ch_exp_o,
  output logic             max_current_o,
  output logic [2:0]       mode_o
);

  // the link timer needs at least two link cycles of low time
  if (SLEEP_CYC * LINK_CLK_HZ / CLK_HZ < 2) begin
    $error("SLEEP_CYC too small");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_r, sda_sync_r;
  logic [1:0] slo_sync_r, hot_sync_r;
  logic       scl_d_r, sda_d_r;
  // the supply monitor resets to supply-low so the core stays in por until the comparator is seen
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      slo_sync_r <= 2'b11;
      hot_sync_r <= 2'b00;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      slo_sync_r <= {slo_sync_r[0], supply_low_lockout_i};
      hot_sync_r <= {hot_sync_r[0], over_temp_i};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end
  wire scl_s   = scl_sync_r[1];
  wire sda_s   = sda_sync_r[1];
  wire supply_low_s = slo_sync_r[1];
  wire over_temp_s  = hot_sync_r[1];
  wire scl_ris = scl_s & ~scl_d_r;
  wire scl_fal = ~scl_s & scl_d_r;
  wire start_c = scl_s & scl_d_r & ~sda_s & sda_d_r;
  wire stop_c  = scl_s & scl_d_r & sda_s & ~sda_d_r;

  // ----------------------------------------------------------------
  // link domain: scl-low sleep timer on link clock, event crosses by toggle
  // ----------------------------------------------------------------
  // link clock is assumed free running; scl is sampled there too
  // the low time is rescaled from system cycles to link cycles
  localparam logic [31:0] LINK_LOW_CYC = 32'(SLEEP_CYC * LINK_CLK_HZ / CLK_HZ);
  logic [1:0]  lscl_sync_r, lsda_sync_r;
  logic [31:0] low_cnt_r;
  logic        sleep_tgl_r;
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lscl_sync_r <= 2'b11;
      lsda_sync_r <= 2'b11;
      low_cnt_r   <= '0;
      sleep_tgl_r <= 1'b0;
    end else begin
      lscl_sync_r <= {lscl_sync_r[0], scl_i};
      lsda_sync_r <= {lsda_sync_r[0], sda_i};
      if (lscl_sync_r[1] || !lsda_sync_r[1]) begin
        low_cnt_r <= '0;
      end else if (low_cnt_r == LINK_LOW_CYC) begin
        sleep_tgl_r <= ~sleep_tgl_r;
        low_cnt_r   <= low_cnt_r + 32'h1;
      end else if (low_cnt_r < LINK_LOW_CYC) begin
        low_cnt_r <= low_cnt_r + 32'h1;
      end
    end
  end

  logic [2:0] sleep_x_r;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) sleep_x_r <= 3'b000;
    else         sleep_x_r <= {sleep_x_r[1:0], sleep_tgl_r};
  end
  wire scl_sleep = sleep_x_r[2] ^ sleep_x_r[1];

  // ----------------------------------------------------------------
  // i2c target
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_REG = 3'b011, I_WR = 3'b010,
    I_RD = 3'b110, I_ACK = 3'b111, I_RACK = 3'b101
  } rgbd_i2c_type;
  rgbd_i2c_type i_st_r, i_ret_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r, ptr_r, wdat_r;
  logic       wr_stb_r, is_rd_r;
  logic       sda_r, sda_oe_r;
  logic [7:0] rdata;
  logic       awake;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      i_st_r <= I_IDLE; i_ret_r <= I_IDLE; bit_r <= 4'h0; sh_r <= 8'h00;
      ptr_r <= 8'h00; wdat_r <= 8'h00; wr_stb_r <= 1'b0; is_rd_r <= 1'b0;
      sda_r <= 1'b1; sda_oe_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (!awake || stop_c) begin
        i_st_r <= I_IDLE; sda_oe_r <= 1'b0;
      end else if (start_c) begin
        i_st_r <= I_ADDR; bit_r <= 4'h0; sda_oe_r <= 1'b0;
      end else begin
        case (i_st_r)
          I_ADDR, I_REG, I_WR: begin
            if (scl_ris) begin
              sh_r  <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fal && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              if (i_st_r == I_ADDR) begin
                if (sh_r[7:1] == TARGET_ADDR) begin
                  is_rd_r  <= sh_r[0];
                  i_ret_r  <= sh_r[0] ? I_RD : I_REG;
                  i_st_r   <= I_ACK; sda_oe_r <= 1'b1; sda_r <= 1'b0;
                end else begin
                  i_st_r <= I_IDLE;
                end
              end else begin
                if (i_st_r == I_REG) ptr_r <= sh_r;
                else begin
                  wdat_r <= sh_r; wr_stb_r <= 1'b1;
                end
                i_ret_r <= I_WR;
                i_st_r  <= I_ACK; sda_oe_r <= 1'b1; sda_r <= 1'b0;
              end
            end
          end
          I_ACK: begin
            if (scl_fal) begin
              if (i_ret_r == I_RD) begin
                sh_r <= rdata; sda_r <= rdata[7]; sda_oe_r <= 1'b1;
              end else sda_oe_r <= 1'b0;
              i_st_r <= i_ret_r;
            end
          end
          I_RD: begin
            if (scl_fal) begin
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h7) begin
                sda_oe_r <= 1'b0; i_st_r <= I_RACK;
                ptr_r    <= ptr_r + 8'h01;
              end else begin
                sh_r <= {sh_r[6:0], 1'b0}; sda_r <= sh_r[6];
              end
            end
          end
          I_RACK: begin
            if (scl_ris) begin
              // a nack from the controller ends the read
              i_st_r <= sda_s ? I_IDLE : I_ACK;
              i_ret_r <= I_RD; bit_r <= 4'h0;
            end
          end
          default: i_st_r <= I_IDLE;
        endcase
        if (wr_stb_r) ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers, flags, commands
  // ----------------------------------------------------------------
  rgbd_mode_type mode_r;
  logic       en_r, por_flag_r, tsd_flag_r;
  logic [7:0] cfg_sh_r [4], cfg_act_r [4], dc_r [3], pwm_tgt_r [3];
  logic       init_clr;
  wire wr_now  = wr_stb_r && (ptr_r != ADDR_FLAGS);
  assign init_clr = (mode_r == MODE_INIT) || (mode_r == MODE_POR);
  wire default_cmd = wr_stb_r && ptr_r == ADDR_DEFAULT_CMD && wdat_r == DEFAULT_CMD_VALUE;
  wire apply_cmd   = wr_stb_r && ptr_r == ADDR_APPLY_CMD && wdat_r == APPLY_CMD_VALUE;
  wire sleep_cmd   = wr_stb_r && ptr_r == ADDR_SLEEP_CMD && wdat_r == SLEEP_CMD_VALUE;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      en_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        cfg_sh_r[i] <= REG_RESET_VALUE; cfg_act_r[i] <= REG_RESET_VALUE;
      end
      for (int i = 0; i < 3; i++) begin
        dc_r[i] <= REG_RESET_VALUE; pwm_tgt_r[i] <= REG_RESET_VALUE;
      end
    end else if (init_clr || default_cmd) begin
      en_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        cfg_sh_r[i] <= REG_RESET_VALUE; cfg_act_r[i] <= REG_RESET_VALUE;
      end
      for (int i = 0; i < 3; i++) begin
        dc_r[i] <= REG_RESET_VALUE; pwm_tgt_r[i] <= REG_RESET_VALUE;
      end
    end else begin
      if (wr_now && ptr_r == ADDR_ENABLE) en_r <= wdat_r[0];
      for (int i = 0; i < 4; i++)
        if (wr_now && ptr_r == ADDR_CFG0 + 8'(i)) cfg_sh_r[i] <= wdat_r;
      if (apply_cmd && en_r) begin
        for (int i = 0; i < 4; i++) cfg_act_r[i] <= cfg_sh_r[i];
      end
      for (int i = 0; i < 3; i++) begin
        if (wr_now && ptr_r == ADDR_DC0 + 8'(i))  dc_r[i]      <= wdat_r;
        if (wr_now && ptr_r == ADDR_PWM0 + 8'(i)) pwm_tgt_r[i] <= wdat_r;
      end
    end
  end

  // hardware set wins over software clear
  wire clr_wr = wr_now && ptr_r == ADDR_FLAG_CLR && en_r;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      por_flag_r <= 1'b0;
      tsd_flag_r <= 1'b0;
    end else begin
      if (mode_r == MODE_INIT) por_flag_r <= 1'b1;
      else if (clr_wr && wdat_r[POWERON_FLAG_CLEAR_BIT]) por_flag_r <= 1'b0;
      if (over_temp_s && mode_r != MODE_SLEEP && mode_r != MODE_POR)
        tsd_flag_r <= 1'b1;
      else if (clr_wr && wdat_r[THERMAL_FLAG_CLEAR_BIT]) tsd_flag_r <= 1'b0;
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (ptr_r == ADDR_ENABLE) rdata = {7'h00, en_r};
    else if (ptr_r >= ADDR_CFG0 && ptr_r <= ADDR_CFG3) rdata = cfg_sh_r[ptr_r[1:0] - 2'd1];
    else if (ptr_r >= ADDR_DC0 && ptr_r < ADDR_DC0 + 8'h03) rdata = dc_r[ptr_r[1:0]];
    else if (ptr_r >= ADDR_PWM0 && ptr_r < ADDR_PWM0 + 8'h03) rdata = pwm_tgt_r[ptr_r[1:0]];
    else if (ptr_r == ADDR_FLAGS) rdata = {6'h00, tsd_flag_r, por_flag_r};
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  logic [2:0] wake_cnt_r;
  logic       sleep_pend_r;
  rgbd_mode_type run_mode;
  // the command acts at the stop, so the ack of its data byte still completes
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) sleep_pend_r <= 1'b0;
    else if (!awake) sleep_pend_r <= 1'b0;
    else if (sleep_cmd) sleep_pend_r <= 1'b1;
  end
  wire enter_sleep = (sleep_pend_r && stop_c) || scl_sleep;
  assign run_mode = en_r ? MODE_NORMAL : MODE_STANDBY;
  assign awake = mode_r != MODE_SLEEP && mode_r != MODE_POR;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_r     <= MODE_POR;
      wake_cnt_r <= 3'h0;
    end else begin
      case (mode_r)
        MODE_POR:  if (!supply_low_s) mode_r <= MODE_INIT;
        MODE_INIT: mode_r <= run_mode;
        MODE_STANDBY, MODE_NORMAL: begin
          if (enter_sleep) mode_r <= MODE_SLEEP;
          else if (over_temp_s) mode_r <= MODE_THERMAL;
          else mode_r <= run_mode;
        end
        MODE_THERMAL: begin
          if (enter_sleep) mode_r <= MODE_SLEEP;
          else if (!over_temp_s) mode_r <= run_mode;
        end
        MODE_SLEEP: begin
          if (!scl_s) wake_cnt_r <= 3'h0;
          else if (!sda_s && sda_d_r) wake_cnt_r <= wake_cnt_r + 3'h1;
          if ((scl_s && !sda_s && sda_d_r && wake_cnt_r == 3'(WAKE_EDGES - 1))
              || (scl_ris && !scl_sleep)) begin
            mode_r <= MODE_INIT;
            wake_cnt_r <= 3'h0;
          end
        end
        default: mode_r <= MODE_POR;
      endcase
      if (supply_low_s) mode_r <= MODE_POR;
    end
  end

  // ----------------------------------------------------------------
  // fade ramps, stepped from the system clock
  // ----------------------------------------------------------------
  function automatic logic [31:0] step_units(input logic [3:0] code);
    case (code)
      4'hB:    step_units = 32'd20;
      4'hC:    step_units = 32'd40;
      4'hD:    step_units = 32'd80;
      4'hE:    step_units = 32'd120;
      4'hF:    step_units = 32'd160;
      default: step_units = {28'h0, code};
    endcase
  endfunction

  logic [31:0] tick_cnt_r;
  logic [7:0]  pwm_cur_r [3];
  wire [3:0]   tcode = cfg_act_r[2][RAMP_TIME_LSB +: 4];
  wire [31:0]  tick_max = step_units(tcode) * 32'(RAMP_UNIT_CYC);
  wire         tick = (tick_cnt_r + 32'h1 >= tick_max);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) tick_cnt_r <= '0;
    else if (tick) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 3; i++) pwm_cur_r[i] <= REG_RESET_VALUE;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!cfg_act_r[2][i] || tcode == 4'h0) pwm_cur_r[i] <= pwm_tgt_r[i];
        else if (tick && pwm_cur_r[i] < pwm_tgt_r[i]) pwm_cur_r[i] <= pwm_cur_r[i] + 8'h01;
        else if (tick && pwm_cur_r[i] > pwm_tgt_r[i]) pwm_cur_r[i] <= pwm_cur_r[i] - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ch0_pwm_o <= 8'h00; ch1_pwm_o <= 8'h00; ch2_pwm_o <= 8'h00;
      ch_on_o <= 3'h0; ch_exp_o <= 3'h0; max_current_o <= 1'b0;
      mode_o <= 3'h0; sda_o <= 1'b1; sda_oe_o <= 1'b0;
    end else begin
      ch0_pwm_o <= pwm_cur_r[0];
      ch1_pwm_o <= pwm_cur_r[1];
      ch2_pwm_o <= pwm_cur_r[2];
      ch_on_o   <= (mode_r == MODE_NORMAL) ? cfg_act_r[1][2:0] : 3'h0;
      ch_exp_o  <= cfg_act_r[3][2:0];
      max_current_o <= cfg_act_r[0][0];
      mode_o    <= mode_r;
      sda_o     <= sda_r;
      sda_oe_o  <= sda_oe_r;
    end
  end

endmodule
`default_nettype wire

//--- design/rgbd_pkg.sv
/*
  package for the led driver control core: register offsets, command values,
  mode encoding and timing constants.
  assumes a 20 mhz system clock and an i2c link clock sampled on its own domain.
*/
package rgbd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE     = 8'h00;
  localparam logic [7:0] ADDR_CFG0       = 8'h01;
  localparam logic [7:0] ADDR_CFG1       = 8'h02;
  localparam logic [7:0] ADDR_CFG2       = 8'h03;
  localparam logic [7:0] ADDR_CFG3       = 8'h04;
  localparam logic [7:0] ADDR_SLEEP_CMD  = 8'h0D;
  localparam logic [7:0] ADDR_DEFAULT_CMD = 8'h0E;
  localparam logic [7:0] ADDR_APPLY_CMD  = 8'h0F;
  localparam logic [7:0] ADDR_FLAG_CLR   = 8'h13;
  localparam logic [7:0] ADDR_DC0        = 8'h14;
  localparam logic [7:0] ADDR_PWM0       = 8'h18;
  localparam logic [7:0] ADDR_FLAGS      = 8'h40;

  // ----------------------------------------------------------------
  // command values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] SLEEP_CMD_VALUE   = 8'h33;
  localparam logic [7:0] DEFAULT_CMD_VALUE = 8'hCC;
  localparam logic [7:0] APPLY_CMD_VALUE   = 8'h55;
  localparam logic [6:0] TARGET_ADDR       = 7'h2D;
  localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
  localparam int         POWERON_FLAG_CLEAR_BIT       = 0;
  localparam int         THERMAL_FLAG_CLEAR_BIT       = 1;
  localparam int         RAMP_TIME_LSB     = 4;
  localparam int         RAMP_STEPS        = 256;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ            = 20000000;
  localparam longint RAMP_UNIT_US      = 50000;
  // one ramp step per unit of 0.05 s divided over 256 steps, rounded down
  localparam longint RAMP_UNIT_CYC     = (RAMP_UNIT_US * CLK_HZ) / (1000000 * RAMP_STEPS);
  localparam longint SCL_LOW_SLEEP_MS  = 100;
  localparam longint SCL_LOW_SLEEP_CYC = SCL_LOW_SLEEP_MS * CLK_HZ / 1000;
  localparam int     WAKE_EDGES        = 8;
  // rate of the link clock that the scl-low timer counts in
  localparam longint LINK_CLK_HZ       = 6250000;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_POR     = 3'b000,
    MODE_INIT    = 3'b001,
    MODE_STANDBY = 3'b011,
    MODE_NORMAL  = 3'b010,
    MODE_THERMAL = 3'b110,
    MODE_SLEEP   = 3'b100
  } rgbd_mode_type;

endpackage

//--- tb/rgbd_core_props.sv
/* checker for rgbd_core: mode sequencing, channel gating and sda timing.
   assumes it is bound into rgbd_core; reset_i is async, active high. */
`timescale 1ns/100ps
`default_nettype none
module rgbd_core_props
  import rgbd_pkg::*;
#(
  parameter longint SLEEP_CYC = SCL_LOW_SLEEP_CYC
) (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       reset_i,
  // monitored pins
  input wire logic       supply_low_lockout_i,
  input wire logic       over_temp_i,
  input wire logic       scl_i,
  input wire logic       sda_oe_o,
  input wire logic [7:0] ch0_pwm_o,
  input wire logic [7:0] ch1_pwm_o,
  input wire logic [7:0] ch2_pwm_o,
  input wire logic [2:0] ch_on_o,
  input wire logic [2:0] mode_o
);
  // ------
  // properties
  // ------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // input synchronisers give a few cycles of slack
  a_por_hold: assert property (supply_low_lockout_i [*5] |-> mode_o == MODE_POR)
    else $error("mode left por under supply low");
  a_init_exit: assert property (
    mode_o == MODE_INIT && !supply_low_lockout_i |=> mode_o inside {MODE_STANDBY, MODE_NORMAL})
    else $error("init not followed by standby or normal");
  a_sleep_exit: assert property (
    mode_o == MODE_SLEEP ##1 mode_o != MODE_SLEEP |-> mode_o inside {MODE_INIT, MODE_POR})
    else $error("shutdown left without init");
  a_hot_off: assert property (over_temp_i [*8] |-> ch_on_o == 3'h0)
    else $error("channels on during overheat");
  a_off_unless_normal: assert property (mode_o != MODE_NORMAL [*2] |-> ch_on_o == 3'h0)
    else $error("channels on outside normal");
  a_thermal_entry: assert property (
    over_temp_i && mode_o inside {MODE_NORMAL, MODE_STANDBY} |-> ##[1:6] mode_o == MODE_THERMAL)
    else $error("no thermal entry");
  a_thermal_hold: assert property (
    mode_o == MODE_THERMAL && over_temp_i |=> mode_o inside {MODE_THERMAL, MODE_SLEEP, MODE_POR})
    else $error("thermal left while hot");
  a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda drive changed with scl high");
  a_init_pwm_zero: assert property (
    mode_o == MODE_INIT |-> ##[0:3] (ch0_pwm_o | ch1_pwm_o | ch2_pwm_o) == 8'h00)
    else $error("pwm not default after init");
  c_thermal: cover property (mode_o == MODE_THERMAL);
  c_sleep: cover property (mode_o == MODE_SLEEP);
  c_ack: cover property ($rose(sda_oe_o));
endmodule
bind rgbd_core rgbd_core_props #(.SLEEP_CYC(SLEEP_CYC)) u_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .supply_low_lockout_i(supply_low_lockout_i),
  .over_temp_i(over_temp_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .ch0_pwm_o(ch0_pwm_o),
  .ch1_pwm_o(ch1_pwm_o), .ch2_pwm_o(ch2_pwm_o), .ch_on_o(ch_on_o), .mode_o(mode_o));
`default_nettype wire

//--- tb/rgbd_i2c_ctl.sv
/* i2c bus controller model driving scl and an open-drain sda.
   assumes a pull-up on sda resolved outside; pins move just after mclk edges. */
`timescale 1ns/100ps
`default_nettype none
module rgbd_i2c_ctl
  import rgbd_pkg::*;
(
  // timing reference
  input  wire logic mclk_i,
  // bus pins
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic pins(input logic s, input logic dl, input int cyc);
    scl_o = s;
    sda_low_o = dl;
    repeat (cyc) @(posedge mclk_i);
    #1;
  endtask
  // quarter bit of 13 cycles keeps scl just under 400 khz
  task automatic bit_io(input logic b, output logic r);
    pins(1'b0, ~b, 13);
    pins(1'b1, ~b, 13);
    r = sda_i;
    pins(1'b1, ~b, 13);
    pins(1'b0, ~b, 13);
  endtask
  task automatic start();
    pins(1'b0, 1'b0, 13);
    pins(1'b1, 1'b0, 13);
    pins(1'b1, 1'b1, 13);
    pins(1'b0, 1'b1, 13);
  endtask
  task automatic stop();
    pins(1'b0, 1'b1, 13);
    pins(1'b1, 1'b1, 13);
    pins(1'b1, 1'b0, 13);
  endtask
  task automatic wbyte(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ok = ok & ~r;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d[$], output logic ok);
    ok = 1'b1;
    start();
    wbyte({TARGET_ADDR, 1'b0}, ok);
    wbyte(ra, ok);
    foreach (d[i]) wbyte(d[i], ok);
    stop();
  endtask
  task automatic rd(input logic [7:0] ra, input int n, output logic [7:0] d[$], output logic ok);
    logic [7:0] b;
    logic       r;
    ok = 1'b1;
    d = {};
    start();
    wbyte({TARGET_ADDR, 1'b0}, ok);
    wbyte(ra, ok);
    start();
    wbyte({TARGET_ADDR, 1'b1}, ok);
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        bit_io(1'b1, r);
        b[k] = r;
      end
      bit_io(i == n - 1, r);
      d.push_back(b);
    end
    stop();
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/* self-checking bench for rgbd_core with an i2c controller model.
   assumes the checker is bound in; sleep timer shortened to 800 cycles. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rgbd_pkg::*;
  localparam longint SLP = 800;
  logic       mclk = 1'b0;
  logic       link_clk = 1'b0;
  logic       reset = 1'b1;
  logic       supply_low = 1'b1;
  logic       over_temp = 1'b0;
  logic       scl, sda_low, sda_out, sda_oe, max_cur, ok;
  logic [7:0] pwm0, pwm1, pwm2;
  logic [7:0] q[$];
  logic [2:0] ch_on, mode, ch_exp;
  wire logic  sda;
  int         failures = 0;
  int         check_count = 0;
  int         cycles = 0;
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  always #25 mclk = ~mclk;
  // link clock starts off the system clock's grid, so their edges never coincide
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end
  rgbd_core #(.SLEEP_CYC(SLP)) uut (
    .mclk_i(mclk), .reset_i(reset), .link_clk_i(link_clk),
    .supply_low_lockout_i(supply_low), .over_temp_i(over_temp), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .ch0_pwm_o(pwm0), .ch1_pwm_o(pwm1), .ch2_pwm_o(pwm2),
    .ch_on_o(ch_on), .ch_exp_o(ch_exp), .max_current_o(max_cur), .mode_o(mode));
  rgbd_i2c_ctl u_ctl (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // ------
  // shared helpers
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrq(input logic [7:0] ra, input logic [7:0] d[$]);
    u_ctl.wr(ra, d, ok);
    chk(8'(ok), 8'h01);
  endtask
  task automatic rd1(input logic [7:0] ra, input logic [7:0] exp);
    u_ctl.rd(ra, 1, q, ok);
    chk(8'(ok), 8'h01);
    chk(q[0], exp);
  endtask
  task automatic wait_mode(input rgbd_mode_type m);
    for (int i = 0; i < 300 && mode !== m; i++) @(posedge mclk);
    @(posedge mclk);
    #1;
    chk(8'(mode), 8'(m));
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_power_on();
    repeat (8) @(posedge mclk);
    #1;
    chk(8'(mode), 8'(MODE_POR));
    supply_low = 1'b0;
    wait_mode(MODE_STANDBY);
    wrq(ADDR_FLAG_CLR, {8'h01});
    rd1(ADDR_FLAGS, 8'h01);
    wrq(ADDR_ENABLE, {8'h01});
    wait_mode(MODE_NORMAL);
    wrq(ADDR_FLAG_CLR, {8'h01});
    rd1(ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_address();
    ok = 1'b1;
    u_ctl.start();
    u_ctl.wbyte({TARGET_ADDR ^ 7'h01, 1'b0}, ok);
    u_ctl.stop();
    chk(8'(ok), 8'h00);
  endtask
  task automatic t_config();
    wrq(ADDR_CFG0, {8'h01, 8'h07, 8'h00, 8'h05});
    chk({4'h0, max_cur, ch_on}, 8'h00);
    chk({5'h00, ch_exp}, 8'h00);
    wrq(ADDR_APPLY_CMD, {APPLY_CMD_VALUE});
    chk({4'h0, max_cur, ch_on}, 8'h0F);
    chk({5'h00, ch_exp}, 8'h05);
    wrq(ADDR_PWM0, {8'h12, 8'h34, 8'h56});
    chk(pwm0, 8'h12);
    chk({pwm1, pwm2} == 16'h3456, 8'h01);
    u_ctl.rd(ADDR_PWM0 + 8'h01, 2, q, ok);
    chk({q[0], q[1]} == 16'h3456, 8'h01);
  endtask
  // code 1: 0.05 s over 256 steps is 3906 cycles a step; a whole ramp would not fit
  // the run, so ten step times are waited (10 or 11 steps with the free step timer)
  localparam int STEP_CYC = 3906;
  task automatic t_ramp();
    wrq(ADDR_CFG2, {8'h11});
    wrq(ADDR_APPLY_CMD, {APPLY_CMD_VALUE});
    wrq(ADDR_PWM0, {8'hFF});
    chk(8'(pwm0 != 8'hFF), 8'h01);
    repeat (10 * STEP_CYC) @(posedge mclk);
    #1;
    chk(8'(pwm0 >= 8'h1C && pwm0 <= 8'h1D), 8'h01);
    wrq(ADDR_CFG2, {8'h01});
    wrq(ADDR_APPLY_CMD, {APPLY_CMD_VALUE});
    chk(pwm0, 8'hFF);
    chk(pwm1, 8'h34);
  endtask
  task automatic t_thermal();
    over_temp = 1'b1;
    wait_mode(MODE_THERMAL);
    chk({5'h00, ch_on}, 8'h00);
    rd1(ADDR_FLAGS, 8'h02);
    over_temp = 1'b0;
    wait_mode(MODE_NORMAL);
    chk({5'h00, ch_on}, 8'h07);
    rd1(ADDR_FLAGS, 8'h02);
    wrq(ADDR_FLAG_CLR, {8'h02});
    rd1(ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_default();
    wrq(ADDR_DEFAULT_CMD, {DEFAULT_CMD_VALUE});
    chk({pwm1, pwm2} == 16'h0000, 8'h01);
  endtask
  task automatic t_sleep_cmd();
    wrq(ADDR_SLEEP_CMD, {SLEEP_CMD_VALUE});
    wait_mode(MODE_SLEEP);
    for (int i = 0; i < 8; i++) begin
      chk(8'(mode), 8'(MODE_SLEEP));
      u_ctl.pins(1'b1, 1'b1, 100);
      u_ctl.pins(1'b1, 1'b0, 100);
    end
    wait_mode(MODE_STANDBY);
    rd1(ADDR_FLAGS, 8'h01);
  endtask
  // two short lows must not add up to the sleep time
  task automatic t_scl_low();
    for (int i = 0; i < 2; i++) begin
      u_ctl.pins(1'b0, 1'b0, 600);
      u_ctl.pins(1'b1, 1'b0, 20);
    end
    chk(8'(mode), 8'(MODE_STANDBY));
    u_ctl.pins(1'b0, 1'b0, 1000);
    chk(8'(mode), 8'(MODE_SLEEP));
    u_ctl.pins(1'b0, 1'b1, 20);
    u_ctl.pins(1'b1, 1'b1, 20);
    u_ctl.pins(1'b1, 1'b0, 20);
    wait_mode(MODE_STANDBY);
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      failures++;
      $display("MISMATCH t=%0t timeout", $time);
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_power_on();
    t_address();
    t_config();
    t_ramp();
    t_thermal();
    t_default();
    t_sleep_cmd();
    t_scl_low();
    report_and_stop();
  end
endmodule
`default_nettype wire
